// [core/mode_timer_pkg.sv]
package mode_timer_pkg;

  // ****************************************************************
  // widths and register map
  // ****************************************************************
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned ADDR_W   = 12;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  localparam logic [ADDR_W-1:0] OFF_CTRL_A   = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_CTRL_B   = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE  = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_COMMUTATION_COMPARE_VALUE     = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_DETECT_START_COMPARE_VALUE     = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_OVERFLOW_COMPARE_VALUE     = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h01C;

  // ctrl a bit positions
  localparam int unsigned A_RUN      = 0;
  localparam int unsigned A_RST_PD   = 1;
  localparam int unsigned A_SW_RST   = 2;
  localparam int unsigned A_RST_OVL  = 3;
  localparam int unsigned A_RST_OVERFLOW_COMPARE_VALUE = 4;
  // ctrl b bit positions
  localparam int unsigned B_CAP_PD   = 1;
  localparam int unsigned B_SW_CAP   = 2;
  localparam int unsigned B_CAP_OVL  = 3;
  localparam int unsigned B_SAT      = 5;
  // irq status bit positions
  localparam int unsigned I_COMMUTATION_COMPARE_VALUE = 0;
  localparam int unsigned I_DETECT_START_COMPARE_VALUE = 1;
  localparam int unsigned I_OVERFLOW_COMPARE_VALUE = 2;
  localparam int unsigned I_SAT  = 3;
  localparam int unsigned IRQ_W  = 4;

  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // control fields held by the unit
  typedef struct packed {
    logic reset_on_third_compare;
    logic reset_on_overload;
    logic reset_on_position_detect;
    logic mode_counter_run;
  } ctrl_a_t;

  typedef struct packed {
    logic capture_on_overload;
    logic capture_on_position_detect;
  } ctrl_b_t;

  // compare-match pulses
  typedef struct packed {
    logic overflow_compare_value;
    logic detect_start_compare_value;
    logic commutation_compare_value;
  } cmp_hit_t;

endpackage : mode_timer_pkg

// [core/compare_timer.sv]
`timescale 1ns/1ns
module compare_timer
  import mode_timer_pkg::*;
#(
  parameter bit GE_MODE = 1'b0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] count,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_value,
  output logic      [CNT_W-1:0] value,
  output logic                  hit
);

  logic armed_reg;
  logic run_d_reg;

  // compare value store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= CNT_ZERO;
    end else if (load) begin
      value <= load_value;
    end
  end

  // greater-or-equal for the commutation timer so a late write still fires
  wire match = GE_MODE ? (count >= value) : (count == value);

  // only a stop cancels a setting, so values loaded before the start stay armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_d_reg <= 1'b0;
    end else begin
      run_d_reg <= run;
    end
  end

  wire run_fell = run_d_reg && !run;

  // one shot: a hit disarms until software writes a new value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (load) begin
      armed_reg <= 1'b1;                   // re-arm on write, also while stopped
    end else if (run_fell) begin
      armed_reg <= 1'b0;                   // clearing the run bit cancels settings
    end else if (hit) begin
      armed_reg <= 1'b0;
    end
  end

  assign hit = run && armed_reg && match;  // only while counting

endmodule : compare_timer

// [core/capture_latch.sv]
`timescale 1ns/1ns
module capture_latch
  import mode_timer_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             take,
  input  wire logic [CNT_W-1:0] count,
  output logic      [CNT_W-1:0] captured
);

  // latest trigger always overwrites, so the value is the newest interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured <= CNT_ZERO;
    end else if (take) begin
      captured <= count;
    end
  end

endmodule : capture_latch

// [core/motor_mode_timer_unit.sv]
`timescale 1ns/1ns
// Overview of operation
// - The mode counter counts up and clears on a position detection event.
// - Three compare timers give commutation, detection-start and overflow interrupts.
// - The count is copied to the capture register on detection or overload when enabled.
// - The counter may be reset by position detection, the third compare timer or overload.
// - Unreset, the counter stops at FFFF and sets the saturated flag.
// - Software reads the running count only by requesting a capture and reading it back.
// - Compare timer one fires on greater-or-equal, timers two and three on equality.
// - Timer one still fires when its value is written after the count passed it.
// - A fired timer stays quiet until a new value is written to its compare register.
// - With detection capture enabled, every detection overwrites the capture register.
// - The counter runs only with its run bit set; clearing it cancels compare settings.
// - Each hardware counter reset source has its own enable bit; software reset is a write-only bit.
// - Overload and detection capture have enables; software capture is a write-only bit.
// - Compare timers act only while the counter runs.
module motor_mode_timer_unit (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [mode_timer_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          position_detect_irq,
  input  wire logic                          overload_signal,
  output logic                               commutation_compare_irq,
  output logic                               detect_start_compare_irq,
  output logic                               overflow_compare_irq,
  output logic                               irq
);
  import mode_timer_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  ctrl_a_t               ctrl_a_reg;
  ctrl_b_t               ctrl_b_reg;
  logic [CNT_W-1:0]      count_reg;                  // sixteen bits
  logic [CNT_W-1:0]      count_next;
  logic                  saturated_reg;
  logic [IRQ_W-1:0]      irq_stat_reg;
  logic [IRQ_W-1:0]      irq_mask_reg;
  logic [IRQ_W-1:0]      irq_events;
  logic [CNT_W-1:0]      capture_value;
  logic [CNT_W-1:0]      commutation_compare_value_value;
  logic [CNT_W-1:0]      detect_start_compare_value_value;
  logic [CNT_W-1:0]      overflow_compare_value_value;
  cmp_hit_t              hits;
  logic                  counter_clear;
  logic                  capture_take;
  logic                  sw_reset;
  logic                  sw_capture;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // single-cycle access phase: pready registered high for the cycle after setup, no wait states
  wire setup_phase = psel && !penable;
  wire wr_access   = psel && penable && pwrite;
  wire rd_setup    = setup_phase && !pwrite;

  function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
    wr_hit = wr_access && (paddr == off);
  endfunction : wr_hit

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    known_addr = (a == OFF_CTRL_A) || (a == OFF_CTRL_B) || (a == OFF_CAPTURE) ||
                 (a == OFF_COMMUTATION_COMPARE_VALUE) || (a == OFF_DETECT_START_COMPARE_VALUE) || (a == OFF_OVERFLOW_COMPARE_VALUE) ||
                 (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
  endfunction : known_addr

  // write-only request bits act as single pulses, never stored
  assign sw_reset   = wr_hit(OFF_CTRL_A) && pwdata[A_SW_RST];
  assign sw_capture = wr_hit(OFF_CTRL_B) && pwdata[B_SW_CAP];

  // compare register writes; each one re-arms its timer
  wire load_commutation_compare_value = wr_hit(OFF_COMMUTATION_COMPARE_VALUE);
  wire load_detect_start_compare_value = wr_hit(OFF_DETECT_START_COMPARE_VALUE);
  wire load_overflow_compare_value = wr_hit(OFF_OVERFLOW_COMPARE_VALUE);

  // a zero written to the saturation bit clears the flag; a one leaves it alone
  wire sat_clear = wr_hit(OFF_CTRL_B) && !pwdata[B_SAT];

  // counter parked at all-ones while running: the saturation condition
  function automatic logic at_ceiling();
    at_ceiling = ctrl_a_reg.mode_counter_run && (count_reg == CNT_MAX);
  endfunction : at_ceiling

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_reg <= '0;
    end else if (wr_hit(OFF_CTRL_A)) begin
      ctrl_a_reg.mode_counter_run         <= pwdata[A_RUN];
      ctrl_a_reg.reset_on_position_detect <= pwdata[A_RST_PD];
      ctrl_a_reg.reset_on_overload        <= pwdata[A_RST_OVL];
      ctrl_a_reg.reset_on_third_compare   <= pwdata[A_RST_OVERFLOW_COMPARE_VALUE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_reg <= '0;
    end else if (wr_hit(OFF_CTRL_B)) begin
      ctrl_b_reg.capture_on_position_detect <= pwdata[B_CAP_PD];
      ctrl_b_reg.capture_on_overload        <= pwdata[B_CAP_OVL];
    end
  end

  // ****************************************************************
  // mode counter
  // ****************************************************************
  // each hardware source is gated by its own enable bit; sw_reset is not gated
  assign counter_clear = (ctrl_a_reg.reset_on_position_detect && position_detect_irq) ||
                         (ctrl_a_reg.reset_on_overload && overload_signal) ||
                         (ctrl_a_reg.reset_on_third_compare && hits.overflow_compare_value) ||
                         sw_reset;

  always_comb begin
    count_next = count_reg;
    if (counter_clear) begin
      count_next = CNT_ZERO;
    end else if (ctrl_a_reg.mode_counter_run && count_reg != CNT_MAX) begin
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= CNT_ZERO;
    end else begin
      count_reg <= count_next;                                  // holds at all-ones
    end
  end

  // saturation flag: hardware set wins over a clearing write of zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saturated_reg <= 1'b0;
    end else if (at_ceiling() && !counter_clear) begin
      saturated_reg <= 1'b1;
    end else if (sat_clear) begin
      saturated_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // compare timers and capture
  // ****************************************************************
  compare_timer #(.GE_MODE(1'b1)) u_commutation_compare_value (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (ctrl_a_reg.mode_counter_run),
    .count      (count_reg),
    .load       (load_commutation_compare_value),
    .load_value (pwdata[CNT_W-1:0]),
    .value      (commutation_compare_value_value),
    .hit        (hits.commutation_compare_value)
  );

  compare_timer #(.GE_MODE(1'b0)) u_detect_start_compare_value (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (ctrl_a_reg.mode_counter_run),
    .count      (count_reg),
    .load       (load_detect_start_compare_value),
    .load_value (pwdata[CNT_W-1:0]),
    .value      (detect_start_compare_value_value),
    .hit        (hits.detect_start_compare_value)
  );

  compare_timer #(.GE_MODE(1'b0)) u_overflow_compare_value (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (ctrl_a_reg.mode_counter_run),
    .count      (count_reg),
    .load       (load_overflow_compare_value),
    .load_value (pwdata[CNT_W-1:0]),
    .value      (overflow_compare_value_value),
    .hit        (hits.overflow_compare_value)
  );

  // capture takes the count before this cycle's clear, i.e. the full interval
  assign capture_take = (ctrl_b_reg.capture_on_position_detect && position_detect_irq) ||
                        (ctrl_b_reg.capture_on_overload && overload_signal) ||
                        sw_capture;

  capture_latch u_capture (
    .pclk     (pclk),
    .presetn  (presetn),
    .take     (capture_take),
    .count    (count_reg),
    .captured (capture_value)
  );

  // ****************************************************************
  // interrupt outputs
  // ****************************************************************
  // registered one-cycle pulses per compare timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      commutation_compare_irq  <= 1'b0;
      detect_start_compare_irq <= 1'b0;
      overflow_compare_irq     <= 1'b0;
    end else begin
      commutation_compare_irq  <= hits.commutation_compare_value;
      detect_start_compare_irq <= hits.detect_start_compare_value;
      overflow_compare_irq     <= hits.overflow_compare_value;
    end
  end

  always_comb begin
    irq_events         = '0;
    irq_events[I_COMMUTATION_COMPARE_VALUE] = hits.commutation_compare_value;
    irq_events[I_DETECT_START_COMPARE_VALUE] = hits.detect_start_compare_value;
    irq_events[I_OVERFLOW_COMPARE_VALUE] = hits.overflow_compare_value;
    irq_events[I_SAT]  = at_ceiling() && !saturated_reg && !counter_clear;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
    end else if (wr_hit(OFF_IRQ_STAT)) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_events;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= '0;
    end else if (wr_hit(OFF_IRQ_MASK)) begin
      irq_mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  // level output straight from a flop, one cycle behind status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // read-back words built from the field positions, so the map is kept in one place
  function automatic logic [31:0] ctrl_a_word();
    logic [31:0] w;
    w             = RDATA_ZERO;
    w[A_RUN]      = ctrl_a_reg.mode_counter_run;
    w[A_RST_PD]   = ctrl_a_reg.reset_on_position_detect;
    w[A_RST_OVL]  = ctrl_a_reg.reset_on_overload;
    w[A_RST_OVERFLOW_COMPARE_VALUE] = ctrl_a_reg.reset_on_third_compare;
    ctrl_a_word   = w;                     // software reset request always reads zero
  endfunction : ctrl_a_word

  function automatic logic [31:0] ctrl_b_word();
    logic [31:0] w;
    w            = RDATA_ZERO;
    w[B_CAP_PD]  = ctrl_b_reg.capture_on_position_detect;
    w[B_CAP_OVL] = ctrl_b_reg.capture_on_overload;
    w[B_SAT]     = saturated_reg;
    ctrl_b_word  = w;                      // write-only capture request reads zero
  endfunction : ctrl_b_word

  // read data registered during setup so it is ready in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RDATA_ZERO;
    end else if (rd_setup) begin
      case (paddr)
        OFF_CTRL_A:   prdata <= ctrl_a_word();
        OFF_CTRL_B:   prdata <= ctrl_b_word();
        OFF_CAPTURE:  prdata <= {16'h0, capture_value};
        OFF_COMMUTATION_COMPARE_VALUE:     prdata <= {16'h0, commutation_compare_value_value};
        OFF_DETECT_START_COMPARE_VALUE:     prdata <= {16'h0, detect_start_compare_value_value};
        OFF_OVERFLOW_COMPARE_VALUE:     prdata <= {16'h0, overflow_compare_value_value};
        OFF_IRQ_STAT: prdata <= {28'h0, irq_stat_reg};
        OFF_IRQ_MASK: prdata <= {28'h0, irq_mask_reg};
        default:      prdata <= RDATA_ZERO;
      endcase
    end
  end

  // unmapped addresses answer with an error in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !known_addr(paddr);
    end
  end

endmodule : motor_mode_timer_unit

// [tb/mode_timer_monitor.sv]
`timescale 1ns/1ns
module mode_timer_monitor
  import mode_timer_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              position_detect_irq,
  input wire logic              overload_signal,
  input wire logic              commutation_compare_irq,
  input wire logic              detect_start_compare_irq,
  input wire logic              overflow_compare_irq,
  input wire logic              irq
);
  // ****************
  // port checks
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       run_q;
  logic [2:0] fired_q;
  logic [2:0] hit;
  logic       wr_acc;
  logic       rd_acc;
  assign hit = {overflow_compare_irq, detect_start_compare_irq, commutation_compare_irq};
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = psel && penable && pready && !pwrite;
  // a fired timer stays fired until its compare register is rewritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      fired_q <= 3'h0;
    end else begin
      if (wr_acc && paddr == OFF_CTRL_A) run_q <= pwdata[A_RUN];
      for (int i = 0; i < 3; i++) begin
        if (wr_acc && paddr == OFF_COMMUTATION_COMPARE_VALUE + 12'(4 * i)) fired_q[i] <= 1'b0;
        else if (hit[i]) fired_q[i] <= 1'b1;
      end
    end
  end
  property p_once1; commutation_compare_irq |-> !fired_q[0]; endproperty
  a_once1: assert property (p_once1) else $error("timer one fired twice");
  property p_once2; detect_start_compare_irq |-> !fired_q[1]; endproperty
  a_once2: assert property (p_once2) else $error("timer two fired twice");
  property p_once3; overflow_compare_irq |-> !fired_q[2]; endproperty
  a_once3: assert property (p_once3) else $error("timer three fired twice");
  property p_run; |hit |-> run_q || $past(run_q); endproperty
  a_run: assert property (p_run) else $error("compare fired while stopped");
  property p_pulse; commutation_compare_irq |=> !commutation_compare_irq; endproperty
  a_pulse: assert property (p_pulse) else $error("timer one pulse too long");
  property p_ge;
    wr_acc && paddr == OFF_COMMUTATION_COMPARE_VALUE && pwdata[15:0] == 16'h0000 && run_q |-> ##[1:4] commutation_compare_irq;
  endproperty
  a_ge: assert property (p_ge) else $error("timer one missed a passed value");
  property p_capw; rd_acc && paddr == OFF_CAPTURE |-> prdata[31:16] == 16'h0000; endproperty
  a_capw: assert property (p_capw) else $error("capture wider than sixteen bits");
  property p_swcap; rd_acc && paddr == OFF_CTRL_B |-> !prdata[B_SW_CAP]; endproperty
  a_swcap: assert property (p_swcap) else $error("capture request bit reads back");
  property p_mask; wr_acc && paddr == OFF_IRQ_MASK && pwdata[3:0] == 4'h0 |-> ##2 !irq; endproperty
  a_mask: assert property (p_mask) else $error("interrupt high with all masked");
  c_commutation_compare_value: cover property (commutation_compare_irq);
  c_overflow_compare_value: cover property (overflow_compare_irq);
  c_irq: cover property (irq);
endmodule : mode_timer_monitor

// [tb/detect_partner.sv]
`timescale 1ns/1ns
module detect_partner (
  input wire logic pclk,
  output logic     position_detect_irq,
  output logic     overload_signal
);
  // ****************
  // far-side events
  // ****************
  // both lines idle low between events
  initial begin
    position_detect_irq = 1'b0;
    overload_signal = 1'b0;
  end
  // one-cycle event pulse, launched right after an edge
  task fire(input int s);
    @(posedge pclk);
    if (s == 0) position_detect_irq <= 1'b1;
    else overload_signal <= 1'b1;
    @(posedge pclk);
    position_detect_irq <= 1'b0;
    overload_signal <= 1'b0;
  endtask : fire
endmodule : detect_partner

// [tb/tb_motor_mode_timer_unit.sv]
`timescale 1ns/1ns
module tb_motor_mode_timer_unit;
  import mode_timer_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready, pslverr, irq, last_err;
  logic              position_detect_irq, overload_signal;
  logic              commutation_compare_irq, detect_start_compare_irq, overflow_compare_irq;
  logic [31:0]       r, v, cb;
  int                failures = 0;
  int                samples_checked = 0;
  int                n [3] = '{0, 0, 0};
  int                k, b;
  motor_mode_timer_unit motor_mode_timer_unit_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .position_detect_irq, .overload_signal,
    .commutation_compare_irq, .detect_start_compare_irq, .overflow_compare_irq, .irq);
  detect_partner detect_partner_i (.pclk, .position_detect_irq, .overload_signal);
  // ****************
  // clock and helpers
  // ****************
  always #5 pclk = ~pclk;
  // count compare pulses so tests look at deltas, not single cycles
  always @(posedge pclk) begin
    n[0] += commutation_compare_irq;
    n[1] += detect_start_compare_irq;
    n[2] += overflow_compare_irq;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // expected count after a known start and a number of clocks, stopping at all-ones
  function automatic logic [31:0] exp_count(input logic [31:0] start, input int clocks);
    exp_count = start + 32'(clocks);
    if (exp_count > 32'(CNT_MAX)) exp_count = 32'(CNT_MAX);
  endfunction : exp_count
  // one apb transfer; held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
  task rd(input logic [11:0] a); apb(1'b0, a, 32'h0); endtask : rd
  // software capture then read back; the count cannot be read directly
  task cap; wr(OFF_CTRL_B, cb | 32'h4); rd(OFF_CAPTURE); endtask : cap
  task idle(input int c); repeat (c) @(posedge pclk); endtask : idle
  task summarize;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // hang guard, well past the saturation wait
  initial begin
    #800000;
    failures++;
    summarize;
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(86));
    cb = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then the unmapped address is refused
    rd(OFF_CTRL_A); chk(r, 0);
    rd(OFF_CAPTURE); chk(r, 0);
    rd(OFF_IRQ_STAT); chk(r, 0);
    rd(12'h020); chk(r, 0);
    chk(last_err, 1);
    wr(OFF_CTRL_A, 32'h1);
    cap; v = r; cap; chk(r, exp_count(v, 6));
    wr(OFF_CTRL_A, 32'h5); cap; chk(r, 2);
    // position detection, then overload, as capture and reset sources
    for (int s = 0; s < 2; s++) begin
      cb = s ? 32'h8 : 32'h2;
      wr(OFF_CTRL_A, s ? 32'h9 : 32'h3);
      cap; v = r; detect_partner_i.fire(s); rd(OFF_CAPTURE); chk(r, exp_count(v, 5));
      k = $urandom % 8; idle(k); cap; chk(r, exp_count(5, k));
      cb = 32'h0;
      wr(OFF_CTRL_A, 32'h1);
      cap; v = r; detect_partner_i.fire(s); rd(OFF_CAPTURE); chk(r, v);
      cap; chk(r, exp_count(v, 11));
    end
    // timer one compares by magnitude, fires once per write
    b = n[0]; wr(OFF_COMMUTATION_COMPARE_VALUE, 32'h0); idle(40); chk(n[0], b + 1);
    wr(OFF_COMMUTATION_COMPARE_VALUE, 32'h0); idle(10); chk(n[0], b + 2);
    // timer two compares by equality only
    wr(OFF_CTRL_A, 32'h5); k = 20 + $urandom % 20; wr(OFF_DETECT_START_COMPARE_VALUE, k); idle(60);
    chk(n[1], 1);
    wr(OFF_DETECT_START_COMPARE_VALUE, 32'h1); idle(60); chk(n[1], 1);
    // timer three resets the counter when enabled
    wr(OFF_CTRL_A, 32'h15); wr(OFF_OVERFLOW_COMPARE_VALUE, 32'd50); idle(80); cap;
    chk(r, 34);
    chk(n[2], 1);
    // status, mask and level interrupt
    rd(OFF_IRQ_STAT); chk(r, 32'h7);
    chk(irq, 0);
    wr(OFF_IRQ_MASK, 32'h2); idle(2); chk(irq, 1);
    wr(OFF_IRQ_STAT, 32'h2); idle(2); chk(irq, 0);
    rd(OFF_IRQ_STAT); chk(r, 32'h5);
    wr(OFF_IRQ_MASK, 32'h0); wr(OFF_IRQ_STAT, 32'hF);
    // stopped counter, and compares written while stopped stay quiet
    wr(OFF_CTRL_A, 32'h0); cap; v = r; cap; chk(r, v);
    b = n[0]; wr(OFF_COMMUTATION_COMPARE_VALUE, 32'h0); idle(10); chk(n[0], b);
    wr(OFF_CTRL_A, 32'h1); idle(10); chk(n[0], b + 1); // loaded before the start
    wr(OFF_COMMUTATION_COMPARE_VALUE, 32'h0); idle(10); chk(n[0], b + 2);
    // a stop after loading cancels the setting
    b = n[1]; wr(OFF_DETECT_START_COMPARE_VALUE, 32'd200); wr(OFF_CTRL_A, 32'h0); wr(OFF_CTRL_A, 32'h5); idle(250);
    chk(n[1], b);
    // saturation after a long unreset run
    wr(OFF_CTRL_A, 32'h5); idle(65600);
    rd(OFF_CTRL_B); chk(r[B_SAT], 1);
    rd(OFF_IRQ_STAT); chk(r, 32'h9);
    cap; chk(r, 32'h0000_FFFF);
    summarize;
  end
endmodule : tb_motor_mode_timer_unit
bind motor_mode_timer_unit mode_timer_monitor mode_timer_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .position_detect_irq, .overload_signal,
  .commutation_compare_irq, .detect_start_compare_irq, .overflow_compare_irq, .irq);
